// [hdl/ptc_top.v]
// Precision time counter with AXI4-Lite register slave
// ----------------------------------------------------------------------
// How it works
// - Test enable bit 0, reset clear, routes a selected signal to observe output.
// - Select 10 drives time bit 12; select 11 drives time bit 14.
// - Select 00 drives target pending flag; select 01 drives time bit 10.
// - Raw low returns live time bits 31:0, read-only, writes ignored.
// - Raw low read latches nothing; raw high returns live upper half.
// - 64-bit loadable up-counter advancing only on accumulator rollover.
// - Addend summed into 32-bit accumulator each cycle; carry increments timer.
// - System low read copies upper half to temp register for high read.
// - Low write held; high write loads all 64 bits at once.
// - Software load beats a coinciding rollover increment.
// - 64-bit target time, reset zero; irq when time >= target and masked in.
// - Target pending sticky until written one; reload target before clearing.
// - Rising trigger edge copies full time into read-only snapshot pair.
// - Trigger input synchronized to the clock before capture.
// - Trigger is strictly an input to this block.
// - Capture sets the snapshot flag in the event register.
// - Flag cleared by writing one; next capture on next rising trigger.
// - Snapshot flag raises irq only while its mask bit is set.
// ----------------------------------------------------------------------
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`include "ptc_defs.vh"

module ptc_top (
  input  wire        core_clk_i,
  input  wire        rstn_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output reg         s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output reg         s_axi_wready_o,
  output reg  [1:0]  s_axi_bresp_o,
  output reg         s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output reg         s_axi_arready_o,
  output reg  [31:0] s_axi_rdata_o,
  output reg  [1:0]  s_axi_rresp_o,
  output reg         s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  input  wire        aux_slave_trigger_i,
  output reg         timesync_irq_o,
  output reg         test_observe_out_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [63:0] sys_time;
  reg  [31:0] accum;
  reg  [31:0] addend;
  reg  [31:0] hold_low;
  reg  [31:0] temp_high;
  reg  [63:0] target_time;
  reg  [63:0] snap_time;
  reg         mask_target;
  reg         mask_snap;
  reg         target_pend;
  reg         snap_flag;
  reg         test_enable;
  reg  [1:0]  test_sel;
  reg         trig_meta;
  reg         trig_sync;
  reg         trig_prev;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // --------------------------------------------------------------------
  // Handshakes, carry and trigger edge
  // --------------------------------------------------------------------
  wire [32:0] accum_sum  = {1'b0, accum} + {1'b0, addend};
  wire        roll_pulse = accum_sum[32];
  wire        aw_take    = s_axi_awvalid_i & s_axi_awready_o;
  wire        w_take     = s_axi_wvalid_i & s_axi_wready_o;
  wire        ar_take    = s_axi_arvalid_i & s_axi_arready_o;
  // One write in flight; the next waits until the answer is taken
  wire        wr_en      = aw_held & w_held & ~s_axi_bvalid_o;
  wire [31:0] wr_word    = w_data;
  // Edge taken on the synchronised level, never on the first stage
  wire        trig_rise  = trig_sync & ~trig_prev;

  // --------------------------------------------------------------------
  // Byte-lane merge of a write into an existing word
  // --------------------------------------------------------------------
  function [31:0] ptc_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer i;
    begin
      ptc_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          ptc_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Register write decode
  // --------------------------------------------------------------------
  wire wr_ctl     = wr_en & (aw_addr == `PTC_OFF_CONTROL);
  wire wr_evt     = wr_en & (aw_addr == `PTC_OFF_EVENT);
  wire wr_addend  = wr_en & (aw_addr == `PTC_OFF_ADDEND);
  wire wr_accum   = wr_en & (aw_addr == `PTC_OFF_ACCUM);
  wire wr_test    = wr_en & (aw_addr == `PTC_OFF_TEST);
  wire wr_sys_lo  = wr_en & (aw_addr == `PTC_OFF_SYS_LOW);
  wire wr_sys_hi  = wr_en & (aw_addr == `PTC_OFF_SYS_HIGH);
  wire wr_tgt_lo  = wr_en & (aw_addr == `PTC_OFF_TARGET_LOW);
  wire wr_tgt_hi  = wr_en & (aw_addr == `PTC_OFF_TARGET_HIGH);
  // Write-one-to-clear bits of the event register
  wire [31:0] evt_bits = ptc_merge(32'h0000_0000, wr_word, w_strb);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function ptc_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `PTC_OFF_CONTROL,
        `PTC_OFF_EVENT,
        `PTC_OFF_ADDEND,
        `PTC_OFF_ACCUM,
        `PTC_OFF_TEST,
        `PTC_OFF_RAW_LOW,
        `PTC_OFF_RAW_HIGH,
        `PTC_OFF_SYS_LOW,
        `PTC_OFF_SYS_HIGH,
        `PTC_OFF_TARGET_LOW,
        `PTC_OFF_TARGET_HIGH,
        `PTC_OFF_SNAP_LOW,
        `PTC_OFF_SNAP_HIGH: ptc_mapped = 1'b1;
        default:            ptc_mapped = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Write channels
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= `PTC_RST_WORD;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `PTC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr_i[7:2], 2'h0};
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      // Ready reopens only a cycle after the answer is taken
      s_axi_awready_o <= ~aw_held & ~aw_take & ~s_axi_bvalid_o;
      s_axi_wready_o  <= ~w_held & ~w_take & ~s_axi_bvalid_o;
      if (wr_en) begin
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= ptc_mapped(aw_addr) ? `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o  <= 1'b0;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------
  // Read word chosen from the address still on the bus at the take
  reg [31:0] rd_mux;
  always @* begin
    case ({s_axi_araddr_i[7:2], 2'h0})
      `PTC_OFF_CONTROL:     rd_mux = {29'h0, mask_snap, mask_target, 1'b0};
      `PTC_OFF_EVENT:       rd_mux = {29'h0, snap_flag, target_pend, 1'b0};
      `PTC_OFF_ADDEND:      rd_mux = addend;
      `PTC_OFF_ACCUM:       rd_mux = accum;
      `PTC_OFF_TEST:        rd_mux = {29'h0, test_sel, test_enable};
      `PTC_OFF_RAW_LOW:     rd_mux = sys_time[31:0];
      `PTC_OFF_RAW_HIGH:    rd_mux = sys_time[63:32];
      `PTC_OFF_SYS_LOW:     rd_mux = sys_time[31:0];
      `PTC_OFF_SYS_HIGH:    rd_mux = temp_high;
      `PTC_OFF_TARGET_LOW:  rd_mux = target_time[31:0];
      `PTC_OFF_TARGET_HIGH: rd_mux = target_time[63:32];
      `PTC_OFF_SNAP_LOW:    rd_mux = snap_time[31:0];
      `PTC_OFF_SNAP_HIGH:   rd_mux = snap_time[63:32];
      default:              rd_mux = `PTC_RST_WORD;
    endcase
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= `PTC_RST_WORD;
      s_axi_rresp_o   <= `PTC_RESP_OKAY;
      temp_high       <= `PTC_RST_WORD;
    end else begin
      if (ar_take) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_mux;
        s_axi_rresp_o   <= ptc_mapped({s_axi_araddr_i[7:2], 2'h0}) ?
                           `PTC_RESP_OKAY : `PTC_RESP_SLVERR;
        // Only the loadable view latches; the raw view does not
        if ({s_axi_araddr_i[7:2], 2'h0} == `PTC_OFF_SYS_LOW) begin
          temp_high <= sys_time[63:32];
        end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end else if (!s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control, test and addend registers
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_target <= 1'b0;
      mask_snap   <= 1'b0;
      test_enable <= 1'b0;
      test_sel    <= 2'h0;
      addend      <= `PTC_RST_WORD;
      hold_low    <= `PTC_RST_WORD;
    end else begin
      if (wr_ctl && w_strb[0]) begin
        mask_target <= wr_word[`PTC_CTL_TARGET_MASK];
        mask_snap   <= wr_word[`PTC_CTL_SNAP_MASK];
      end
      if (wr_test && w_strb[0]) begin
        test_enable <= wr_word[`PTC_TST_ENABLE];
        test_sel    <= wr_word[`PTC_TST_SEL_MSB:`PTC_TST_SEL_LSB];
      end
      if (wr_addend) begin
        addend <= ptc_merge(addend, wr_word, w_strb);
      end
      if (wr_sys_lo) begin
        hold_low <= ptc_merge(hold_low, wr_word, w_strb);
      end
    end
  end

  // --------------------------------------------------------------------
  // Accumulator and system timer
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      accum <= `PTC_RST_WORD;
    end else if (wr_accum) begin
      accum <= ptc_merge(accum, wr_word, w_strb);
    end else begin
      accum <= accum_sum[31:0];
    end
  end

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_time <= `PTC_RST_TIME;
    end else begin
      if (wr_sys_hi) begin
        // Load wins; the rollover of this cycle is dropped
        sys_time <= {ptc_merge(sys_time[63:32], wr_word, w_strb), hold_low};
      end else if (roll_pulse) begin
        sys_time <= sys_time + 64'h0000_0000_0000_0001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Target time and pending flag
  // --------------------------------------------------------------------
  // Full 64-bit compare; pending follows it while the target is met
  wire target_hit = (sys_time >= target_time);

  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      target_time <= `PTC_RST_TIME;
      // Time 0 already meets target 0
      target_pend <= `PTC_RST_TARGET_PEND;
    end else begin
      if (wr_tgt_lo) begin
        target_time[31:0] <= ptc_merge(target_time[31:0], wr_word, w_strb);
      end
      if (wr_tgt_hi) begin
        target_time[63:32] <= ptc_merge(target_time[63:32], wr_word, w_strb);
      end
      // Set beats a write-one clear in the same cycle
      if (target_hit) begin
        target_pend <= 1'b1;
      end else if (wr_evt && evt_bits[`PTC_EVT_TARGET_PEND]) begin
        target_pend <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Auxiliary slave snapshot
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      // Idle level of the trigger, so reset makes no false edge
      trig_prev <= 1'b0;
      snap_time <= `PTC_RST_TIME;
      snap_flag <= 1'b0;
    end else begin
      trig_meta <= aux_slave_trigger_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      // A set flag blocks new captures until software clears it
      if (trig_rise && !snap_flag) begin
        snap_time <= sys_time;
        snap_flag <= 1'b1;
      end else if (wr_evt && evt_bits[`PTC_EVT_SNAP_FLAG]) begin
        snap_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Test observation select
  // --------------------------------------------------------------------
  reg next_observe;
  always @* begin
    case (test_sel)
      `PTC_SEL_PEND:  next_observe = target_pend;
      `PTC_SEL_BIT12: next_observe = sys_time[`PTC_OBS_BIT12];
      `PTC_SEL_BIT14: next_observe = sys_time[`PTC_OBS_BIT14];
      default:        next_observe = sys_time[`PTC_OBS_BIT10];
    endcase
  end

  // --------------------------------------------------------------------
  // Interrupt request and test observation output
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timesync_irq_o     <= 1'b0;
      test_observe_out_o <= 1'b0;
    end else begin
      timesync_irq_o     <= (target_pend & mask_target) | (snap_flag & mask_snap);
      test_observe_out_o <= test_enable & next_observe;
    end
  end

endmodule // ptc_top

// [hdl/ptc_defs.vh]
// Register offsets, field positions and reset values of the time counter
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PTC_OFF_CONTROL      8'h00
`define PTC_OFF_EVENT        8'h04
`define PTC_OFF_ADDEND       8'h08
`define PTC_OFF_ACCUM        8'h0c
`define PTC_OFF_TEST         8'h10
`define PTC_OFF_RAW_LOW      8'h18
`define PTC_OFF_RAW_HIGH     8'h1c
`define PTC_OFF_SYS_LOW      8'h20
`define PTC_OFF_SYS_HIGH     8'h24
`define PTC_OFF_TARGET_LOW   8'h28
`define PTC_OFF_TARGET_HIGH  8'h2c
`define PTC_OFF_SNAP_LOW     8'h30
`define PTC_OFF_SNAP_HIGH    8'h34

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTC_CTL_TARGET_MASK  1
`define PTC_CTL_SNAP_MASK    2
`define PTC_EVT_TARGET_PEND  1
`define PTC_EVT_SNAP_FLAG    2
`define PTC_TST_ENABLE       0
`define PTC_TST_SEL_LSB      1
`define PTC_TST_SEL_MSB      2

// ----------------------------------------------------------------------
// Test output select codes and observed time bits
// ----------------------------------------------------------------------
`define PTC_SEL_PEND         2'h0
`define PTC_SEL_BIT12        2'h2
`define PTC_SEL_BIT14        2'h3
`define PTC_OBS_BIT10        10
`define PTC_OBS_BIT12        12
`define PTC_OBS_BIT14        14

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PTC_RST_WORD         32'h0000_0000
`define PTC_RST_TIME         64'h0000_0000_0000_0000
`define PTC_RST_TARGET_PEND  1'b1
`define PTC_RESP_OKAY        2'h0
`define PTC_RESP_SLVERR      2'h2

`endif

// [tb/ptc_top_assertions.sv]
// Checker of bus handshakes and output timing of the time counter
`timescale 1ns/100ps
module ptc_checker (
  input wire        core_clk_i,
  input wire        rstn_i,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_wvalid_i,
  input wire        s_axi_wready_o,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire        timesync_irq_o,
  input wire        test_observe_out_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_b_after_take: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write answer late");
  a_b_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write answer dropped");
  a_b_ends: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o
    ##1 (s_axi_awready_o && s_axi_wready_o)) else $error("write end wrong");
  a_aw_closed: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write ready while answering");
  a_r_after_take: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_r_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read answer dropped");
  a_ar_closed: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read ready while answering");
  a_r_ends: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o
    && s_axi_arready_o) else $error("read end wrong");
  a_irq_quiet_reset: assert property ($rose(rstn_i) |-> !timesync_irq_o
    ##1 !timesync_irq_o) else $error("irq after reset");
  a_obs_quiet_reset: assert property ($rose(rstn_i) |-> ##1 !test_observe_out_o)
    else $error("observe out after reset");
endmodule // ptc_checker

bind ptc_top ptc_checker i_ptc_checker (.*);

// [tb/ptc_bench.sv]
// Self-checking bench of the time counter
`timescale 1ns/100ps
`include "ptc_defs.vh"
module ptc_bench;
  reg        clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  reg        arv = 1'b0, rry = 1'b0, trig = 1'b0;
  reg        late_ready = 1'b0;
  reg [7:0]  awa = 8'h00, ara = 8'h00;
  reg [31:0] wd = 32'h0;
  wire       awr, wr_rdy, bv, arr, rv, irq, obs;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  integer    fail_count = 0;
  integer    check_count = 0;
  integer    i;

  always #10 clk = ~clk;

  ptc_top i_ptc_top (.core_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .aux_slave_trigger_i(trig), .timesync_irq_o(irq),
    .test_observe_out_o(obs));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input string nm, input [31:0] s, input [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wt(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= !late_ready;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv && !bry) bry <= 1'b1;
    end while (bv !== 1'b1 || bry !== 1'b1);
    bry <= 1'b0;
    chk("bresp", {30'h0, br}, {30'h0, er});
  endtask

  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= !late_ready;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv && !rry) rry <= 1'b1;
    end while (rv !== 1'b1 || rry !== 1'b1);
    d = rdt;
    r = rr;
    rry <= 1'b0;
  endtask

  task rc(input [7:0] a, input [31:0] e);
    reg [31:0] v;
    reg [1:0]  s;
    rd(a, v, s);
    chk("rdata", v, e);
    chk("rresp", {30'h0, s}, {30'h0, `PTC_RESP_OKAY});
  endtask

  task w(input [7:0] a, input [31:0] d);
    wr(a, d, `PTC_RESP_OKAY);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    reg [31:0] v;
    reg [1:0]  s;
    for (i = 'h18; i <= 'h34; i = i + 4) rc(i[7:0], `PTC_RST_WORD);
    rc(`PTC_OFF_EVENT, 32'h2);
    rc(`PTC_OFF_TEST, 32'h0);
    // Answer ready held back one cycle so the slave must wait
    late_ready = 1'b1;
    rd(8'h14, v, s);
    chk("unmapped rdata", v, 32'h0);
    chk("unmapped rresp", {30'h0, s}, {30'h0, `PTC_RESP_SLVERR});
    wr(8'h14, 32'h1, `PTC_RESP_SLVERR);
    late_ready = 1'b0;
    $display("t_reset done");
  endtask

  task t_load;
    reg [31:0] v;
    reg [1:0]  s;
    w(`PTC_OFF_SYS_LOW, 32'hffff_ffe0);
    w(`PTC_OFF_SYS_HIGH, 32'h1);
    rc(`PTC_OFF_RAW_LOW, 32'hffff_ffe0);
    rc(`PTC_OFF_RAW_HIGH, 32'h1);
    w(`PTC_OFF_RAW_LOW, 32'h1234);
    rc(`PTC_OFF_RAW_LOW, 32'hffff_ffe0);
    w(`PTC_OFF_ADDEND, 32'hffff_ffff);
    rd(`PTC_OFF_SYS_LOW, v, s);
    chk("low before wrap", {31'h0, v >= 32'hffff_ffe0}, 32'h1);
    wt(60);
    rc(`PTC_OFF_SYS_HIGH, 32'h1);
    rc(`PTC_OFF_RAW_HIGH, 32'h2);
    w(`PTC_OFF_SYS_LOW, 32'h100);
    w(`PTC_OFF_SYS_HIGH, 32'h5);
    rc(`PTC_OFF_RAW_LOW, 32'h102);
    w(`PTC_OFF_ADDEND, 32'h0);
    $display("t_load done");
  endtask

  task t_target;
    w(`PTC_OFF_SYS_LOW, 32'h10);
    w(`PTC_OFF_SYS_HIGH, 32'h0);
    w(`PTC_OFF_TARGET_LOW, 32'h20);
    w(`PTC_OFF_TARGET_HIGH, 32'h0);
    w(`PTC_OFF_EVENT, 32'h2);
    rc(`PTC_OFF_EVENT, 32'h0);
    w(`PTC_OFF_CONTROL, 32'h2);
    wt(3);
    chk("irq", {31'h0, irq}, 32'h0);
    w(`PTC_OFF_SYS_LOW, 32'h20);
    w(`PTC_OFF_SYS_HIGH, 32'h0);
    wt(3);
    chk("irq", {31'h0, irq}, 32'h1);
    w(`PTC_OFF_EVENT, 32'h2);
    rc(`PTC_OFF_EVENT, 32'h2);
    w(`PTC_OFF_CONTROL, 32'h0);
    wt(2);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("t_target done");
  endtask

  task t_observe;
    w(`PTC_OFF_TARGET_HIGH, 32'hffff_ffff);
    w(`PTC_OFF_EVENT, 32'h2);
    w(`PTC_OFF_SYS_LOW, 32'h4400);
    w(`PTC_OFF_SYS_HIGH, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      w(`PTC_OFF_TEST, (i << 1) | 1);
      wt(2);
      chk("observe", {31'h0, obs}, i & 1);
    end
    w(`PTC_OFF_TEST, 32'h2);
    wt(2);
    chk("observe off", {31'h0, obs}, 32'h0);
    $display("t_observe done");
  endtask

  task t_snapshot;
    w(`PTC_OFF_SYS_LOW, 32'h1234_5678);
    w(`PTC_OFF_SYS_HIGH, 32'h7);
    w(`PTC_OFF_CONTROL, 32'h4);
    @(posedge clk) trig <= 1'b1;
    wt(2);
    chk("irq", {31'h0, irq}, 32'h0);
    wt(4);
    chk("irq", {31'h0, irq}, 32'h1);
    rc(`PTC_OFF_EVENT, 32'h4);
    rc(`PTC_OFF_SNAP_LOW, 32'h1234_5678);
    rc(`PTC_OFF_SNAP_HIGH, 32'h7);
    w(`PTC_OFF_SYS_LOW, 32'habc);
    w(`PTC_OFF_SYS_HIGH, 32'h9);
    w(`PTC_OFF_EVENT, 32'h4);
    wt(6);
    rc(`PTC_OFF_EVENT, 32'h0);
    rc(`PTC_OFF_SNAP_LOW, 32'h1234_5678);
    @(posedge clk) trig <= 1'b0;
    wt(4);
    @(posedge clk) trig <= 1'b1;
    wt(6);
    rc(`PTC_OFF_SNAP_LOW, 32'habc);
    rc(`PTC_OFF_SNAP_HIGH, 32'h9);
    w(`PTC_OFF_CONTROL, 32'h0);
    wt(2);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("t_snapshot done");
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    wt(2);
    t_reset;
    t_load;
    t_target;
    t_observe;
    t_snapshot;
    test_done;
  end

  initial begin
    #100000;
    fail_count++;
    test_done;
  end
endmodule // ptc_bench
